/* hdl/ps2c_regs.svh */
// register offsets, field positions, reset values and timing counts of the aux channel
`ifndef PS2C_REGS_SVH
`define PS2C_REGS_SVH

`define PS2C_OFF_CTRL 12'h000
`define PS2C_OFF_STATUS 12'h004
`define PS2C_OFF_TX 12'h008
`define PS2C_OFF_RX 12'h00C

`define PS2C_CTRL_EN_BIT 0
`define PS2C_CTRL_DIR_BIT 1

`define PS2C_ST_RDY_BIT 0
`define PS2C_ST_IDLE_BIT 1
`define PS2C_ST_PERR_BIT 2
`define PS2C_ST_FERR_BIT 3
`define PS2C_ST_TOUT_BIT 4
`define PS2C_ST_BUSY_BIT 5

`define PS2C_RST_EN 1'b0
`define PS2C_RST_IDLE 1'b1

`define PS2C_CLK_MHZ 200
`define PS2C_START_MIN_NS 45
`define PS2C_CLKREL_MIN_NS 90
`define PS2C_DIRCLR_MIN_NS 3500
`define PS2C_FRAME_MAX_NS 2002000
`define PS2C_CYC_UP(ns) ((((ns) * `PS2C_CLK_MHZ) + 999) / 1000)
`define PS2C_CYC_DN(ns) (((ns) * `PS2C_CLK_MHZ) / 1000)

`endif

/* hdl/ps2c_pkg.sv */
// types shared by the aux channel controller
package ps2c_pkg;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ps2c_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ps2c_apb_rsp_t;

  typedef struct packed {
    logic clk_o;
    logic clk_oe;
    logic dat_o;
    logic dat_oe;
  } ps2c_line_t;

  typedef enum logic [3:0] {
    PS2C_DIS, PS2C_IDLE, PS2C_TXPREP, PS2C_TXSTART, PS2C_TXBITS,
    PS2C_TXACK, PS2C_TXWAIT, PS2C_RXBITS, PS2C_RXHOLD
  } ps2c_state_t;

  typedef struct packed {
    ps2c_state_t st;
    logic en;
    logic dir;
    logic idle;
    logic rdy;
    logic perr;
    logic ferr;
    logic tout;
    logic clk_oe;
    logic dat_oe;
    logic irq;
    logic clk_prev;
    logic [3:0] bcnt;
    logic [10:0] wc;
    logic [18:0] ft;
    logic [9:0] tx_sh;
    logic [10:0] rx_sh;
    logic [7:0] rx_data;
    logic [31:0] prdata;
  } ps2c_regs_t;

  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
  } ps2c_sync_t;

endpackage

/* hdl/ps2c_sync.sv */
// two-flop synchroniser for the aux clock and data pins
`timescale 1ns/1ps
`default_nettype none
module ps2c_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] d,
  output logic [1:0] q
);
  import ps2c_pkg::*;

  ps2c_sync_t r, n;

  always_comb begin
    n = r;
    n.s1 = d;
    n.s2 = r.s1;
  end

  // lines idle high, so the chain resets to the released level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{s1: 2'h3, s2: 2'h3};
    end else begin
      r <= n;
    end
  end

  assign q = r.s2;
endmodule // ps2c_sync
`default_nettype wire

/* hdl/ps2c_top.sv */
// aux keyboard/mouse serial channel with an APB register slave
`timescale 1ns/1ps
`default_nettype none
`include "ps2c_regs.svh"

// Operation
// - with enable set and receive selected, release clock and data within 1000 ns.
// - selecting transmit direction pulls the clock line low.
// - start bit driven low 45 to 90 ns after the transmit register write.
// - clock line released 90 to 130 ns after the transmit register write.
// - transmit idle flag clears within 1.7 units of the clock release.
// - first to tenth falling clock edge of a frame takes at most 2.002 ms.
// - next transmit bit presented within 1 us of a falling clock edge.
// - direction bit cleared 3.5 to 7.1 us after the rise following fall eleven.
// - transmit idle flag set within 500 ns of the direction bit falling.
// - data line released once the direction bit returns low.
// - interrupt raised when the transmit idle flag becomes set.
// - receive samples the data line on every falling clock edge.
// - receive data ready set within 1.6 us of the eleventh falling edge.
// - reading the receive register clears data ready within 500 ns.
// - after reception the clock is released only once the receive register is read.
// - with enable cleared, clock driven low and data left floating.
// - interrupt raised when receive data ready becomes set.
module ps2c_top #(
  parameter int unsigned FRAME_MAX_CYC = `PS2C_CYC_DN(`PS2C_FRAME_MAX_NS)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire ps2c_pkg::ps2c_apb_req_t apb_req,
  output ps2c_pkg::ps2c_apb_rsp_t apb_rsp,
  input wire logic aux_clock_line_i,
  input wire logic aux_data_line_i,
  output ps2c_pkg::ps2c_line_t aux_line,
  output logic irq
);
  import ps2c_pkg::*;

  localparam logic [10:0] START_CYC = 11'(`PS2C_CYC_UP(`PS2C_START_MIN_NS));
  localparam logic [10:0] CLKREL_CYC = 11'(`PS2C_CYC_UP(`PS2C_CLKREL_MIN_NS));
  localparam logic [10:0] DIRCLR_CYC = 11'(`PS2C_CYC_UP(`PS2C_DIRCLR_MIN_NS));
  localparam ps2c_regs_t RST = '{st: PS2C_DIS, en: `PS2C_RST_EN, idle: `PS2C_RST_IDLE,
                                 clk_oe: 1'b1, clk_prev: 1'b1, default: '0};

  function automatic logic odd_par(input logic [7:0] d);
    odd_par = ~(^d);
  endfunction

  ps2c_regs_t r, n;
  logic [1:0] pins_s;
  logic s_clk;
  logic s_dat;
  logic fall;
  logic rise;
  logic access;
  logic setup;
  logic mapped;
  logic ctrl_wr;
  logic stat_wr;
  logic tx_wr;
  logic tx_go;
  logic rx_rd;
  logic [10:0] rx_new;

  ps2c_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({aux_clock_line_i, aux_data_line_i}),
    .q(pins_s)
  );

  assign s_clk = pins_s[1];
  assign s_dat = pins_s[0];
  assign fall = r.clk_prev & ~s_clk;
  assign rise = ~r.clk_prev & s_clk;
  assign rx_new = {s_dat, r.rx_sh[10:1]};

  assign setup = apb_req.psel & ~apb_req.penable;
  assign access = apb_req.psel & apb_req.penable;
  assign mapped = (apb_req.paddr == `PS2C_OFF_CTRL) || (apb_req.paddr == `PS2C_OFF_STATUS) ||
                  (apb_req.paddr == `PS2C_OFF_TX) || (apb_req.paddr == `PS2C_OFF_RX);
  assign ctrl_wr = access & apb_req.pwrite & (apb_req.paddr == `PS2C_OFF_CTRL);
  assign stat_wr = access & apb_req.pwrite & (apb_req.paddr == `PS2C_OFF_STATUS);
  assign tx_wr = access & apb_req.pwrite & (apb_req.paddr == `PS2C_OFF_TX);
  assign rx_rd = access & ~apb_req.pwrite & (apb_req.paddr == `PS2C_OFF_RX);
  // a transmit write only starts a byte while the channel is prepared for it
  assign tx_go = tx_wr & (r.st == PS2C_TXPREP) & r.dir;

  function automatic logic [31:0] rd_mux(input logic [11:0] a, input ps2c_regs_t s);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      `PS2C_OFF_CTRL: begin
        v[`PS2C_CTRL_EN_BIT] = s.en;
        v[`PS2C_CTRL_DIR_BIT] = s.dir;
      end
      `PS2C_OFF_STATUS: begin
        v[`PS2C_ST_RDY_BIT] = s.rdy;
        v[`PS2C_ST_IDLE_BIT] = s.idle;
        v[`PS2C_ST_PERR_BIT] = s.perr;
        v[`PS2C_ST_FERR_BIT] = s.ferr;
        v[`PS2C_ST_TOUT_BIT] = s.tout;
        v[`PS2C_ST_BUSY_BIT] = (s.st != PS2C_IDLE) && (s.st != PS2C_DIS);
      end
      `PS2C_OFF_TX: v[9:0] = s.tx_sh;
      `PS2C_OFF_RX: v[7:0] = s.rx_data;
      default: v = 32'h0000_0000;
    endcase
    rd_mux = v;
  endfunction

  always_comb begin
    n = r;
    n.irq = 1'b0;
    n.clk_prev = s_clk;
    if (setup) begin
      n.prdata = rd_mux(apb_req.paddr, r);
    end
    if (ctrl_wr) begin
      n.en = apb_req.pwdata[`PS2C_CTRL_EN_BIT];
      n.dir = apb_req.pwdata[`PS2C_CTRL_DIR_BIT];
    end
    // error flags clear on write of one; sets further down win the same cycle
    if (stat_wr) begin
      n.perr = r.perr & ~apb_req.pwdata[`PS2C_ST_PERR_BIT];
      n.ferr = r.ferr & ~apb_req.pwdata[`PS2C_ST_FERR_BIT];
      n.tout = r.tout & ~apb_req.pwdata[`PS2C_ST_TOUT_BIT];
    end
    if (rx_rd) begin
      n.rdy = 1'b0;
    end
    if ((r.st == PS2C_TXBITS || r.st == PS2C_RXBITS) && r.bcnt != 4'h0 && r.bcnt < 4'hA) begin
      n.ft = r.ft + 19'h00001;
    end
    case (r.st)
      PS2C_DIS: begin
        if (r.en) begin
          n.st = r.rdy ? PS2C_RXHOLD : PS2C_IDLE;
          n.clk_oe = r.rdy;
          n.dat_oe = 1'b0;
        end
      end
      PS2C_IDLE: begin
        n.clk_oe = 1'b0;
        n.dat_oe = 1'b0;
        n.bcnt = 4'h0;
        n.ft = 19'h00000;
        if (r.dir) begin
          n.st = PS2C_TXPREP;
          n.clk_oe = 1'b1;
        end else if (fall && !s_dat) begin
          n.st = PS2C_RXBITS;
          n.rx_sh = rx_new;
          n.bcnt = 4'h1;
        end
      end
      PS2C_TXPREP: begin
        n.clk_oe = 1'b1;
        if (!r.dir) begin
          n.st = PS2C_IDLE;
          n.clk_oe = 1'b0;
        end else if (tx_go) begin
          n.st = PS2C_TXSTART;
          n.wc = 11'h000;
          n.tx_sh = {1'b1, odd_par(apb_req.pwdata[7:0]), apb_req.pwdata[7:0]};
        end
      end
      PS2C_TXSTART: begin
        n.wc = r.wc + 11'h001;
        if (r.wc == START_CYC - 11'h001) begin
          n.dat_oe = 1'b1;
        end
        if (r.wc == CLKREL_CYC - 11'h001) begin
          n.clk_oe = 1'b0;
          n.idle = 1'b0;
          n.st = PS2C_TXBITS;
          n.bcnt = 4'h0;
          n.ft = 19'h00000;
        end
      end
      PS2C_TXBITS: begin
        if (fall) begin
          n.bcnt = r.bcnt + 4'h1;
          if (r.bcnt == 4'hA) begin
            // eleventh fall: the peripheral should hold data low as acknowledge
            n.ferr = n.ferr | s_dat;
            n.st = PS2C_TXACK;
          end else begin
            n.dat_oe = ~r.tx_sh[0];
            n.tx_sh = {1'b0, r.tx_sh[9:1]};
          end
        end
      end
      PS2C_TXACK: begin
        if (rise) begin
          n.st = PS2C_TXWAIT;
          n.wc = 11'h000;
        end
      end
      PS2C_TXWAIT: begin
        n.wc = r.wc + 11'h001;
        if (r.wc == DIRCLR_CYC - 11'h001) begin
          n.dir = 1'b0;
          n.dat_oe = 1'b0;
          n.idle = 1'b1;
          n.irq = 1'b1;
          n.st = PS2C_IDLE;
        end
      end
      PS2C_RXBITS: begin
        if (r.dir) begin
          n.st = PS2C_TXPREP;
          n.clk_oe = 1'b1;
        end else if (fall) begin
          n.rx_sh = rx_new;
          n.bcnt = r.bcnt + 4'h1;
          if (r.bcnt == 4'hA) begin
            n.rx_data = rx_new[8:1];
            // built on n so a write-one clear in this cycle is not undone by a clean frame
            n.perr = n.perr | (odd_par(rx_new[8:1]) != rx_new[9]);
            n.ferr = n.ferr | ~rx_new[10];
            n.rdy = 1'b1;
            n.irq = 1'b1;
            n.clk_oe = 1'b1;
            n.st = PS2C_RXHOLD;
          end
        end
      end
      PS2C_RXHOLD: begin
        n.clk_oe = 1'b1;
        if (rx_rd) begin
          n.clk_oe = 1'b0;
          n.st = PS2C_IDLE;
        end
      end
      default: begin
        n.st = PS2C_DIS;
      end
    endcase
    // a frame that overruns its time limit is dropped and reported
    if ({13'h0000, r.ft} >= FRAME_MAX_CYC[31:0]) begin
      n.tout = 1'b1;
      n.ft = 19'h00000;
      n.dat_oe = 1'b0;
      n.clk_oe = 1'b0;
      n.st = PS2C_IDLE;
      if (r.st == PS2C_TXBITS) begin
        n.dir = 1'b0;
        n.idle = 1'b1;
        n.irq = 1'b1;
      end
    end
    if (!r.en) begin
      n.st = PS2C_DIS;
      n.clk_oe = 1'b1;
      n.dat_oe = 1'b0;
      n.bcnt = 4'h0;
      n.ft = 19'h00000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= RST;
    end else begin
      r <= n;
    end
  end

  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = access & ~mapped;
  assign apb_rsp.prdata = r.prdata;
  assign aux_line.clk_o = 1'b0;
  assign aux_line.clk_oe = r.clk_oe;
  assign aux_line.dat_o = 1'b0;
  assign aux_line.dat_oe = r.dat_oe;
  assign irq = r.irq;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // data still floating after edge nine, pulled low by edge nineteen
  sequence s_tx_start;
    ##9 !aux_line.dat_oe ##[1:10] aux_line.dat_oe;
  endsequence

  a_rx_lines_free: assert property (r.en && !r.dir && r.st == PS2C_IDLE && $past(r.st) == PS2C_IDLE
    |-> !aux_line.clk_oe && !aux_line.dat_oe) else $error("lines not released");
  a_tx_prep_clk: assert property ($rose(r.dir) && r.en && r.st == PS2C_IDLE
    |-> ##1 aux_line.clk_oe) else $error("clock not pulled low");
  a_start_bit_time: assert property (tx_go |-> s_tx_start)
    else $error("start bit late or early");
  a_clk_rel_time: assert property (tx_go |-> ##18 aux_line.clk_oe ##[1:9] !aux_line.clk_oe)
    else $error("clock release out of window");
  a_idle_clear: assert property ($fell(aux_line.clk_oe) && r.st == PS2C_TXBITS |-> !r.idle)
    else $error("idle flag not cleared");
  a_dir_end_idle: assert property ($fell(r.dir) && r.en && $past(r.st) == PS2C_TXWAIT
    |-> r.idle && !aux_line.dat_oe && irq) else $error("end of transmit wrong");
  a_idle_irq: assert property ($rose(r.idle) |-> irq) else $error("no idle interrupt");
  a_rdy_irq: assert property ($rose(r.rdy) |-> irq && aux_line.clk_oe)
    else $error("no receive interrupt");
  a_rd_clears_rdy: assert property (rx_rd |-> ##1 !r.rdy ##1 !r.rdy)
    else $error("ready not cleared");
  a_hold_until_rd: assert property (r.rdy && r.en |-> aux_line.clk_oe)
    else $error("clock released before read");
  a_disabled_lines: assert property (!r.en && $past(!r.en)
    |-> aux_line.clk_oe && !aux_line.dat_oe) else $error("disabled lines wrong");
endmodule // ps2c_top
`default_nettype wire

/* verification/ps2c_periph_model.sv */
// behavioural keyboard/mouse peripheral on the far side of the aux lines
`timescale 1ns/1ps
`default_nettype none
module ps2c_periph_model (
  input wire logic clk_oe,
  input wire logic dat_oe,
  output logic clk_drv,
  output logic dat_drv
);
  // both lines have pull-ups: a released line reads 1
  wire clk_line = ~clk_oe & clk_drv;
  wire dat_line = ~dat_oe & dat_drv;
  initial begin
    clk_drv = 1'b1;
    dat_drv = 1'b1;
  end
  // host-bound frame: start, d0..d7, odd parity, stop; bad_par flips the parity bit
  task automatic send_frame(input logic [7:0] b, input logic bad_par);
    logic [10:0] f;
    f = {1'b1, ~^b ^ bad_par, b, 1'b0};
    wait (clk_line === 1'b1);
    for (int i = 0; i < 11; i++) begin
      dat_drv = f[i];
      #12 clk_drv = 1'b0;
      #24 clk_drv = 1'b1;
      #12;
    end
    dat_drv = 1'b1;
  endtask
  // frame that stops after nb low bits, leaving both lines idle high
  task automatic send_cut(input int nb);
    wait (clk_line === 1'b1);
    for (int i = 0; i < nb; i++) begin
      dat_drv = 1'b0;
      #12 clk_drv = 1'b0;
      #24 clk_drv = 1'b1;
      #12;
    end
    dat_drv = 1'b1;
  endtask
  // device-bound frame: lat is the answer delay after the start bit shows
  task automatic recv_frame(input int lat, output logic [7:0] b, output logic ok);
    logic [9:0] s;
    wait (clk_line === 1'b1 && dat_line === 1'b0);
    #(lat);
    for (int i = 0; i < 11; i++) begin
      clk_drv = 1'b0;
      #24 clk_drv = 1'b1;
      #20;
      if (i < 10) s[i] = dat_line;
      if (i == 9) dat_drv = 1'b0;
      if (i == 10) dat_drv = 1'b1;
      #4;
    end
    b = s[7:0];
    ok = (s[8] === ~^s[7:0]) && (s[9] === 1'b1);
  endtask
endmodule // ps2c_periph_model
`default_nettype wire

/* verification/test_ps2_channel_controller.sv */
// self-checking bench of the aux channel controller with a peripheral model
`timescale 1ns/1ps
`default_nettype none
`include "ps2c_regs.svh"
module test_ps2_channel_controller;
  import ps2c_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  ps2c_apb_req_t apb_req = '0;
  ps2c_apb_rsp_t apb_rsp;
  ps2c_line_t aux_line;
  logic irq;
  logic clk_drv;
  logic dat_drv;
  wire clk_line = ~aux_line.clk_oe & clk_drv;
  wire dat_line = ~aux_line.dat_oe & dat_drv;
  int errors = 0;
  int total_checks = 0;
  int seed = 32'hd3cd;
  logic [31:0] rdata;
  logic rerr;
  logic [7:0] exp_q[$];
  logic [7:0] b;
  logic [7:0] got;
  logic ok;
  int irq_cnt = 0;
  int since_rise = 0;
  int since_fall = 0;
  int rise_gap = 0;
  int fall_gap = 0;
  int n;
  int td;
  int tc;
  logic clk_prev = 1'b0;
  // frame limit cut down so a stuck frame times out quickly
  localparam int FRAME_CYC = 20000;
  always #2.5 pclk = ~pclk;
  ps2c_top #(.FRAME_MAX_CYC(FRAME_CYC)) ps2c_top_i (
    .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .aux_clock_line_i(clk_line), .aux_data_line_i(dat_line), .aux_line(aux_line), .irq(irq)
  );
  ps2c_periph_model ps2c_periph_model_i (
    .clk_oe(aux_line.clk_oe), .dat_oe(aux_line.dat_oe), .clk_drv(clk_drv), .dat_drv(dat_drv)
  );
  // gaps from the last line edges to each interrupt pulse
  always @(posedge pclk) begin
    since_rise = (clk_line === 1'b1 && clk_prev === 1'b0) ? 0 : since_rise + 1;
    since_fall = (clk_line === 1'b0 && clk_prev === 1'b1) ? 0 : since_fall + 1;
    clk_prev = clk_line;
    if (irq === 1'b1) begin
      irq_cnt++;
      rise_gap = since_rise;
      fall_gap = since_fall;
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string msg);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (apb_rsp.pready !== 1'b1 && k < 50);
    rdata = apb_rsp.prdata;
    rerr = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    chk(k < 50, 1'b1, "apb no answer");
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #400000;
    errors++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    wrap_up();
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    chk({aux_line.clk_oe, aux_line.dat_oe}, 2'b10, "disabled lines");
    chk({aux_line.clk_o, aux_line.dat_o}, 2'b00, "open drain level");
    apb(1'b0, `PS2C_OFF_CTRL, 32'h0);
    chk(rdata, 32'h0, "ctrl reset");
    apb(1'b0, `PS2C_OFF_STATUS, 32'h0);
    chk(rdata, 32'h2, "status reset");
    apb(1'b0, 12'h0F0, 32'h0);
    chk({rerr, rdata}, {1'b1, 32'h0}, "unmapped read");
    $display("test reset done");
    apb(1'b1, `PS2C_OFF_CTRL, 32'h1);
    repeat (200) @(posedge pclk);
    chk({aux_line.clk_oe, aux_line.dat_oe}, 2'b00, "receive release");
    for (int k = 0; k < 3; k++) begin
      b = 8'($random(seed));
      exp_q.push_back(b);
      n = irq_cnt;
      ps2c_periph_model_i.send_frame(b, 1'b0);
      repeat (20) @(posedge pclk);
      chk(irq_cnt, n + 1, "rx irq");
      chk(fall_gap <= 320, 1'b1, "rdy late");
      chk(aux_line.clk_oe, 1'b1, "clock held");
      apb(1'b0, `PS2C_OFF_STATUS, 32'h0);
      chk(rdata[1:0], 2'b11, "rdy set");
      apb(1'b0, `PS2C_OFF_RX, 32'h0);
      chk(rdata[7:0], exp_q.pop_front(), "rx byte");
      apb(1'b0, `PS2C_OFF_STATUS, 32'h0);
      chk(rdata[0], 1'b0, "rdy clear");
      chk(aux_line.clk_oe, 1'b0, "clock freed");
    end
    ps2c_periph_model_i.send_frame(8'hA5, 1'b1);
    repeat (20) @(posedge pclk);
    apb(1'b0, `PS2C_OFF_STATUS, 32'h0);
    chk(rdata[2], 1'b1, "parity error");
    apb(1'b1, `PS2C_OFF_STATUS, 32'h1C);
    apb(1'b0, `PS2C_OFF_STATUS, 32'h0);
    chk(rdata[2], 1'b0, "error cleared");
    apb(1'b0, `PS2C_OFF_RX, 32'h0);
    // a frame that stops after three bits is dropped once the limit runs out
    ps2c_periph_model_i.send_cut(3);
    repeat (FRAME_CYC - 100) @(posedge pclk);
    apb(1'b0, `PS2C_OFF_STATUS, 32'h0);
    chk(rdata[4], 1'b0, "timeout too early");
    repeat (200) @(posedge pclk);
    apb(1'b0, `PS2C_OFF_STATUS, 32'h0);
    chk(rdata[5:4], 2'b01, "frame timeout");
    chk(rdata[0], 1'b0, "cut frame data");
    chk({aux_line.clk_oe, aux_line.dat_oe}, 2'b00, "cut frame lines");
    apb(1'b1, `PS2C_OFF_STATUS, 32'h10);
    ps2c_periph_model_i.send_frame(8'h3C, 1'b0);
    repeat (20) @(posedge pclk);
    apb(1'b0, `PS2C_OFF_RX, 32'h0);
    chk(rdata[7:0], 8'h3C, "rx after timeout");
    apb(1'b0, `PS2C_OFF_STATUS, 32'h0);
    chk(rdata[4], 1'b0, "timeout cleared");
    $display("test receive done");
    // a transmit write outside the prepared state must start nothing
    apb(1'b1, `PS2C_OFF_TX, 32'h55);
    repeat (30) @(posedge pclk);
    chk({aux_line.clk_oe, aux_line.dat_oe}, 2'b00, "tx write refused");
    for (int k = 0; k < 2; k++) begin
      b = 8'($random(seed));
      apb(1'b1, `PS2C_OFF_CTRL, 32'h3);
      repeat (2) @(posedge pclk);
      chk(aux_line.clk_oe, 1'b1, "tx prepare");
      n = irq_cnt;
      td = 0;
      tc = 0;
      fork
        ps2c_periph_model_i.recv_frame((k == 0) ? 100 : 3000, got, ok);
        begin
          apb(1'b1, `PS2C_OFF_TX, {24'h0, b});
          for (int c = 1; c <= 30; c++) begin
            @(posedge pclk);
            if (aux_line.dat_oe === 1'b1 && td == 0) td = c;
            if (aux_line.clk_oe === 1'b0 && tc == 0) tc = c;
          end
          chk(td >= 10 && td <= 19, 1'b1, "start bit timing");
          chk(tc >= 19 && tc <= 27, 1'b1, "clock release timing");
          apb(1'b0, `PS2C_OFF_STATUS, 32'h0);
          chk(rdata[1], 1'b0, "idle cleared");
          chk(rdata[5], 1'b1, "busy in transmit");
        end
      join
      chk({ok, got}, {1'b1, b}, "tx frame");
      for (int i = 0; i < 2000 && irq_cnt == n; i++) @(posedge pclk);
      chk(irq_cnt, n + 1, "tx irq");
      chk(rise_gap >= 700 && rise_gap <= 1420, 1'b1, "dir clear timing");
      chk(aux_line.dat_oe, 1'b0, "data freed");
      apb(1'b0, `PS2C_OFF_CTRL, 32'h0);
      chk(rdata, 32'h1, "dir cleared");
      apb(1'b0, `PS2C_OFF_STATUS, 32'h0);
      chk(rdata[1], 1'b1, "idle set");
    end
    $display("test transmit done");
    apb(1'b1, `PS2C_OFF_CTRL, 32'h0);
    repeat (2) @(posedge pclk);
    chk({aux_line.clk_oe, aux_line.dat_oe}, 2'b10, "disable");
    $display("test disable done");
    wrap_up();
  end
endmodule // test_ps2_channel_controller
`default_nettype wire
